// ### rfmm_decoder.sv
`timescale 1ns/1ps
// Function
// [RULE_01] Base-relative emulated opcodes map four to a macro address, 0x0020 to 0x03E0 by 0x40.
// [RULE_02] Indexed opcodes 40x-43x map by nibble x to 0x0030 through 0x03F0 by 0x40.
// [RULE_03] Opcode 48 maps to 0x0480, 49 to 0x0490, 4AX1-4AXB to 0x0050-0x02D0, 4F to 0x02D0.
// [RULE_04] Opcodes 50H-FFH map to the word with low byte cleared, shifted right four.
// [RULE_05] Shared base-relative entries leave the original opcode readable for the macro.
// [RULE_06] Bit 15 is mode, bits 14-10 opcode, 9-5 destination, 4-0 source.
// [RULE_07] Mode 1 makes the source a five-bit literal, mode 0 a source register.
// [RULE_08] Register mode with source 11111 fetches a second word as immediate data.
// [RULE_09] Operands are byte, word or long word, byte only for byte instructions.
// [RULE_10] A byte operand is the low eight bits of the selected 16-bit register.
// [RULE_11] Long operands use 10 even/odd pairs of the 20 registers, even holding the upper half.
// [RULE_12] Fixed-point data is two's complement with the top bit as sign.
// [RULE_13] The wide product register takes multiply high half, divide remainder and shifts.
// [RULE_14] Code-memory load and store use the wide product register as the address.
// [RULE_15] The push/pop pointer changes only by push and pop, which address through it.
// [RULE_16] The 20-bit saved counter captures the program counter on calls, jumps, interrupts.
// [RULE_17] Unlisted emulated opcodes below 50H go to one invalid-opcode handler address.
module rfmm_decoder (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fetch_valid_i,
  input wire logic [15:0] fetch_word_i,
  output logic fetch_ready_o,
  input wire logic byte_op_i,
  output logic dec_valid_o,
  input wire logic dec_ready_i,
  output rfmm_pkg::rfmm_dec_t dec_o,
  output logic [31:0] src_operand_o,
  input wire logic legacy_valid_i,
  input wire logic [15:0] legacy_word_i,
  output logic macro_valid_o,
  output logic [15:0] macro_addr_o,
  output logic macro_invalid_o,
  output logic [15:0] legacy_opcode_o,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_dest_i,
  input wire logic wr_byte_i,
  input wire logic [31:0] wr_data_i,
  input wire logic prod_wr_i,
  input wire logic [31:0] prod_data_i,
  input wire rfmm_pkg::rfmm_stack_op_t stack_op_i,
  output logic [15:0] stack_addr_o,
  output logic stack_valid_o,
  input wire logic cm_req_i,
  input wire logic cm_write_i,
  output logic [31:0] cm_addr_o,
  output logic cm_valid_o,
  output logic cm_write_o,
  input wire logic capture_i,
  input wire logic [19:0] program_counter_i,
  output logic [19:0] saved_counter_o
);

  // decodes a five-bit register code into a register index or pair
  function automatic rfmm_pkg::rfmm_reg_sel_t reg_sel(input logic [4:0] code);
    rfmm_pkg::rfmm_reg_sel_t s;
    s = '{valid: 1'b1, pair: 1'b0, prod: 1'b0, idx: code};
    if (code[4]) begin
      unique case (code[3:0])
        4'h1: s.idx = 5'd16;
        4'h3: s.idx = 5'd17;
        4'h9: s.idx = 5'd18;
        4'hb: s.idx = 5'd19;
        4'h5: s = '{valid: 1'b1, pair: 1'b1, prod: 1'b0, idx: 5'd16};
        4'hd: s = '{valid: 1'b1, pair: 1'b1, prod: 1'b0, idx: 5'd18};
        4'hf: s = '{valid: 1'b1, pair: 1'b0, prod: 1'b1, idx: 5'd0};
        4'h7: s = '{valid: 1'b0, pair: 1'b0, prod: 1'b0, idx: 5'd0};
        default: s = '{valid: 1'b1, pair: 1'b1, prod: 1'b0, idx: {1'b0, code[3:0]}};
      endcase
    end
    return s;
  endfunction

  rfmm_pkg::rfmm_state_t state_q, state_d;
  rfmm_pkg::rfmm_dec_t dec_q, dec_d;
  logic [15:0] gp_q [rfmm_pkg::NUM_GP_REGS];
  logic [31:0] product_q;
  logic [15:0] push_pop_pointer_q;
  logic [19:0] saved_counter_q;
  logic [31:0] operand_q;
  logic [15:0] macro_addr_q;
  logic macro_valid_q;
  logic macro_invalid_q;
  logic [15:0] legacy_opcode_q;
  logic [15:0] stack_addr_q;
  logic stack_valid_q;
  logic cm_valid_q;
  logic cm_write_q;

  wire fetch_take = fetch_valid_i && fetch_ready_o;
  wire is_long = !fetch_word_i[rfmm_pkg::MODE_BIT] &&
                 (fetch_word_i[rfmm_pkg::SRC_MSB:rfmm_pkg::SRC_LSB] == rfmm_pkg::SRC_IMM_LONG);

  assign fetch_ready_o = (state_q != rfmm_pkg::RFMM_HOLD);
  assign dec_valid_o = (state_q == rfmm_pkg::RFMM_HOLD);

  always_comb begin
    state_d = state_q;
    dec_d = dec_q;
    unique case (state_q)
      rfmm_pkg::RFMM_IDLE: begin
        if (fetch_take) begin
          dec_d.mode = fetch_word_i[rfmm_pkg::MODE_BIT]; // [RULE_06]
          dec_d.opcode = fetch_word_i[rfmm_pkg::OPC_MSB:rfmm_pkg::OPC_LSB];
          dec_d.dst = fetch_word_i[rfmm_pkg::DST_MSB:rfmm_pkg::DST_LSB];
          dec_d.src = fetch_word_i[rfmm_pkg::SRC_MSB:rfmm_pkg::SRC_LSB];
          dec_d.long_fmt = is_long; // [RULE_08]
          dec_d.imm = 16'h0000;
          state_d = is_long ? rfmm_pkg::RFMM_IMM : rfmm_pkg::RFMM_HOLD;
        end
      end
      rfmm_pkg::RFMM_IMM: begin
        if (fetch_take) begin
          dec_d.imm = fetch_word_i; // [RULE_08]
          state_d = rfmm_pkg::RFMM_HOLD;
        end
      end
      rfmm_pkg::RFMM_HOLD: begin
        if (dec_ready_i) begin
          state_d = rfmm_pkg::RFMM_IDLE;
        end
      end
      default: state_d = rfmm_pkg::RFMM_IDLE;
    endcase
  end

  // source operand, resolved from the decode about to be held
  rfmm_pkg::rfmm_reg_sel_t src_sel;
  logic [31:0] src_full;
  logic [31:0] operand_d;
  logic [4:0] src_lo_idx;
  assign src_sel = reg_sel(dec_d.src);
  assign src_lo_idx = src_sel.idx + 5'd1;

  always_comb begin
    if (dec_d.mode) begin
      src_full = {{27{dec_d.src[4]}}, dec_d.src}; // [RULE_07] [RULE_12]
    end else if (dec_d.long_fmt) begin
      src_full = {{16{dec_d.imm[15]}}, dec_d.imm}; // [RULE_08]
    end else if (!src_sel.valid) begin
      src_full = 32'h0000_0000;
    end else if (src_sel.prod) begin
      src_full = product_q;
    end else if (src_sel.pair) begin
      src_full = {gp_q[src_sel.idx], gp_q[src_lo_idx]}; // [RULE_11]
    end else begin
      src_full = {{16{gp_q[src_sel.idx][15]}}, gp_q[src_sel.idx]}; // [RULE_12]
    end
    operand_d = byte_op_i ? {24'h00_0000, src_full[7:0]} : src_full; // [RULE_09] [RULE_10]
  end

  wire enter_hold = (state_q != rfmm_pkg::RFMM_HOLD) && (state_d == rfmm_pkg::RFMM_HOLD);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= rfmm_pkg::RFMM_IDLE;
      dec_q <= '0;
      operand_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      dec_q <= dec_d;
      if (enter_hold) begin
        operand_q <= operand_d;
      end
    end
  end

  assign dec_o = dec_q;
  assign src_operand_o = operand_q;

  // emulated opcode to macro entry
  wire [7:0] lop = legacy_word_i[15:8];
  wire [3:0] lnib = legacy_word_i[7:4];
  wire [3:0] lsub = legacy_word_i[3:0];
  wire [3:0] imm_ofs = lsub - rfmm_pkg::IMM_SUB_LO;
  logic [15:0] macro_d;
  logic invalid_d;

  always_comb begin
    invalid_d = 1'b0;
    macro_d = rfmm_pkg::MACRO_INVALID;
    if (lop >= rfmm_pkg::OP_DIRECT_MAP_LO) begin
      macro_d = {4'h0, lop, 4'h0}; // [RULE_04]
    end else if (lop < rfmm_pkg::OP_INDEXED_LO) begin
      macro_d = rfmm_pkg::MACRO_BASE_REL | {6'h00, lop[5:2], 6'h00}; // [RULE_01] [RULE_05]
    end else if (lop <= rfmm_pkg::OP_INDEXED_HI) begin
      macro_d = rfmm_pkg::MACRO_INDEXED | {6'h00, lnib, 6'h00}; // [RULE_02] [RULE_05]
    end else if (lop == rfmm_pkg::OP_IO_TRANSFER) begin
      macro_d = rfmm_pkg::MACRO_IO_TRANSFER; // [RULE_03]
    end else if (lop == rfmm_pkg::OP_VEC_TRANSFER) begin
      macro_d = rfmm_pkg::MACRO_VEC_TRANSFER; // [RULE_03]
    end else if (lop == rfmm_pkg::OP_NATIVE_ESCAPE) begin
      macro_d = rfmm_pkg::MACRO_NATIVE_ESCAPE; // [RULE_03]
    end else if (lop == rfmm_pkg::OP_IMM_GROUP && lsub >= rfmm_pkg::IMM_SUB_LO &&
                 lsub <= rfmm_pkg::IMM_SUB_HI) begin
      macro_d = rfmm_pkg::MACRO_IMM + {6'h00, imm_ofs, 6'h00}; // [RULE_03]
    end else begin
      invalid_d = 1'b1; // [RULE_17]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      macro_valid_q <= 1'b0;
      macro_addr_q <= 16'h0000;
      macro_invalid_q <= 1'b0;
      legacy_opcode_q <= 16'h0000;
    end else begin
      macro_valid_q <= legacy_valid_i;
      if (legacy_valid_i) begin
        macro_addr_q <= macro_d;
        macro_invalid_q <= invalid_d;
        legacy_opcode_q <= legacy_word_i; // [RULE_05]
      end
    end
  end

  assign macro_valid_o = macro_valid_q;
  assign macro_addr_o = macro_addr_q;
  assign macro_invalid_o = macro_invalid_q;
  assign legacy_opcode_o = legacy_opcode_q;

  // register file writes; byte writes touch only the low eight bits
  rfmm_pkg::rfmm_reg_sel_t wr_sel;
  logic [4:0] wr_lo_idx;
  assign wr_sel = reg_sel(wr_dest_i);
  assign wr_lo_idx = wr_sel.idx + 5'd1;
  wire wr_gp = wr_en_i && wr_sel.valid && !wr_sel.prod;
  wire wr_prod = wr_en_i && wr_sel.valid && wr_sel.prod;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < rfmm_pkg::NUM_GP_REGS; i++) begin
        gp_q[i] <= rfmm_pkg::GP_RESET;
      end
    end else if (wr_gp) begin
      if (wr_sel.pair && wr_byte_i) begin
        gp_q[wr_lo_idx][7:0] <= wr_data_i[7:0]; // [RULE_10]
      end else if (wr_sel.pair) begin
        gp_q[wr_sel.idx] <= wr_data_i[31:16]; // [RULE_11]
        gp_q[wr_lo_idx] <= wr_data_i[15:0];
      end else if (wr_byte_i) begin
        gp_q[wr_sel.idx][7:0] <= wr_data_i[7:0]; // [RULE_10]
      end else begin
        gp_q[wr_sel.idx] <= wr_data_i[15:0];
      end
    end
  end

  // arithmetic results take priority over an ordinary register write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      product_q <= rfmm_pkg::PRODUCT_RESET;
    end else if (prod_wr_i) begin
      product_q <= prod_data_i; // [RULE_13]
    end else if (wr_prod && wr_byte_i) begin
      product_q[7:0] <= wr_data_i[7:0];
    end else if (wr_prod) begin
      product_q <= wr_data_i;
    end
  end

  // push pre-decrements, pop post-increments
  wire [15:0] push_addr = push_pop_pointer_q - 16'h0001;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      push_pop_pointer_q <= rfmm_pkg::PUSH_POP_RESET;
      stack_addr_q <= 16'h0000;
      stack_valid_q <= 1'b0;
    end else begin
      stack_valid_q <= (stack_op_i != rfmm_pkg::RFMM_STK_NONE);
      if (stack_op_i == rfmm_pkg::RFMM_STK_PUSH) begin
        push_pop_pointer_q <= push_addr; // [RULE_15]
        stack_addr_q <= push_addr;
      end else if (stack_op_i == rfmm_pkg::RFMM_STK_POP) begin
        push_pop_pointer_q <= push_pop_pointer_q + 16'h0001; // [RULE_15]
        stack_addr_q <= push_pop_pointer_q;
      end
    end
  end

  assign stack_addr_o = stack_addr_q;
  assign stack_valid_o = stack_valid_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cm_valid_q <= 1'b0;
      cm_write_q <= 1'b0;
      saved_counter_q <= rfmm_pkg::SAVED_CNT_RESET;
    end else begin
      cm_valid_q <= cm_req_i;
      if (cm_req_i) begin
        cm_write_q <= cm_write_i;
      end
      if (capture_i) begin
        saved_counter_q <= program_counter_i; // [RULE_16]
      end
    end
  end

  assign cm_addr_o = product_q; // [RULE_14]
  assign cm_valid_o = cm_valid_q;
  assign cm_write_o = cm_write_q;
  assign saved_counter_o = saved_counter_q;

  // checks
  sequence s_long_first;
    state_q == rfmm_pkg::RFMM_IDLE && fetch_valid_i && is_long;
  endsequence

  sequence s_long_second;
    state_q == rfmm_pkg::RFMM_IMM && fetch_valid_i;
  endsequence

  property p_base_rel;
    @(posedge clk_i) disable iff (!rst_n_i)
    legacy_valid_i && lop < 8'h40 |=> macro_addr_o == 16'h0020 + {6'h00, $past(lop[5:2]), 6'h00};
  endproperty
  a_base_rel: assert property (p_base_rel) else $error("base-relative macro wrong"); // [RULE_01]

  property p_indexed;
    @(posedge clk_i) disable iff (!rst_n_i)
    legacy_valid_i && lop >= 8'h40 && lop <= 8'h43
    |=> macro_addr_o == 16'h0030 + {6'h00, $past(lnib), 6'h00};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed macro wrong"); // [RULE_02]

  property p_fixed_map;
    @(posedge clk_i) disable iff (!rst_n_i)
    legacy_valid_i && (lop == 8'h48 || lop == 8'h49)
    |=> macro_addr_o == ($past(lop[0]) ? 16'h0490 : 16'h0480) && !macro_invalid_o;
  endproperty
  a_fixed_map: assert property (p_fixed_map) else $error("transfer opcode macro wrong"); // [RULE_03]

  property p_direct;
    @(posedge clk_i) disable iff (!rst_n_i)
    legacy_valid_i && lop >= 8'h50 |=> macro_addr_o == ($past(legacy_word_i) & 16'hff00) >> 4;
  endproperty
  a_direct: assert property (p_direct) else $error("direct macro wrong"); // [RULE_04]

  property p_invalid;
    @(posedge clk_i) disable iff (!rst_n_i)
    legacy_valid_i && (lop == 8'h44 || lop == 8'h4e)
    |=> macro_invalid_o && macro_addr_o == rfmm_pkg::MACRO_INVALID;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid opcode not routed"); // [RULE_17]

  property p_fields;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == rfmm_pkg::RFMM_IDLE && fetch_valid_i && !is_long
    |=> dec_valid_o && dec_o.opcode == $past(fetch_word_i[14:10]) &&
        dec_o.dst == $past(fetch_word_i[9:5]);
  endproperty
  a_fields: assert property (p_fields) else $error("field split wrong"); // [RULE_06]

  property p_literal;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == rfmm_pkg::RFMM_IDLE && fetch_valid_i && fetch_word_i[15] && !byte_op_i
    |=> src_operand_o == {{27{$past(fetch_word_i[4])}}, $past(fetch_word_i[4:0])};
  endproperty
  a_literal: assert property (p_literal) else $error("literal not sign-extended"); // [RULE_07]

  property p_long_imm;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_long_first ##1 s_long_second |=> dec_valid_o && dec_o.long_fmt &&
      dec_o.imm == $past(fetch_word_i);
  endproperty
  a_long_imm: assert property (p_long_imm) else $error("immediate word not taken"); // [RULE_08]

  property p_stack;
    @(posedge clk_i) disable iff (!rst_n_i)
    stack_op_i == rfmm_pkg::RFMM_STK_NONE |=> $stable(push_pop_pointer_q);
  endproperty
  a_stack: assert property (p_stack) else $error("stack pointer moved"); // [RULE_15]

  property p_capture;
    @(posedge clk_i) disable iff (!rst_n_i)
    capture_i |=> saved_counter_o == $past(program_counter_i);
  endproperty
  a_capture: assert property (p_capture) else $error("counter not captured"); // [RULE_16]

  property p_product;
    @(posedge clk_i) disable iff (!rst_n_i)
    prod_wr_i |=> cm_addr_o == $past(prod_data_i);
  endproperty
  a_product: assert property (p_product) else $error("product pointer wrong"); // [RULE_13]

endmodule

// ### rfmm_pkg.sv
package rfmm_pkg;

  // instruction word fields
  localparam int unsigned MODE_BIT = 15;
  localparam int unsigned OPC_MSB = 14;
  localparam int unsigned OPC_LSB = 10;
  localparam int unsigned DST_MSB = 9;
  localparam int unsigned DST_LSB = 5;
  localparam int unsigned SRC_MSB = 4;
  localparam int unsigned SRC_LSB = 0;

  localparam logic [4:0] SRC_IMM_LONG = 5'h1f;
  localparam logic [4:0] SRC_PUSH_POP = 5'h17;
  localparam int unsigned NUM_GP_REGS = 20;

  // emulated opcode to macro entry map
  localparam logic [7:0] OP_INDEXED_LO = 8'h40;
  localparam logic [7:0] OP_INDEXED_HI = 8'h43;
  localparam logic [7:0] OP_IO_TRANSFER = 8'h48;
  localparam logic [7:0] OP_VEC_TRANSFER = 8'h49;
  localparam logic [7:0] OP_IMM_GROUP = 8'h4a;
  localparam logic [7:0] OP_NATIVE_ESCAPE = 8'h4f;
  localparam logic [7:0] OP_DIRECT_MAP_LO = 8'h50;
  localparam logic [15:0] MACRO_BASE_REL = 16'h0020;
  localparam logic [15:0] MACRO_INDEXED = 16'h0030;
  localparam logic [15:0] MACRO_IMM = 16'h0050;
  localparam logic [15:0] MACRO_STEP = 16'h0040;
  localparam logic [15:0] MACRO_IO_TRANSFER = 16'h0480;
  localparam logic [15:0] MACRO_VEC_TRANSFER = 16'h0490;
  localparam logic [15:0] MACRO_NATIVE_ESCAPE = 16'h02d0;
  localparam logic [15:0] MACRO_INVALID = 16'h0010;
  localparam logic [3:0] IMM_SUB_LO = 4'h1;
  localparam logic [3:0] IMM_SUB_HI = 4'hb;

  // reset values
  localparam logic [15:0] GP_RESET = 16'h0000;
  localparam logic [31:0] PRODUCT_RESET = 32'h0000_0000;
  localparam logic [15:0] PUSH_POP_RESET = 16'h0000;
  localparam logic [19:0] SAVED_CNT_RESET = 20'h0_0000;

  typedef enum logic [1:0] {
    RFMM_IDLE = 2'b00,
    RFMM_IMM = 2'b01,
    RFMM_HOLD = 2'b11
  } rfmm_state_t;

  typedef enum logic [1:0] {
    RFMM_STK_NONE = 2'b00,
    RFMM_STK_PUSH = 2'b01,
    RFMM_STK_POP = 2'b10
  } rfmm_stack_op_t;

  typedef struct packed {
    logic mode;
    logic [4:0] opcode;
    logic [4:0] dst;
    logic [4:0] src;
    logic long_fmt;
    logic [15:0] imm;
  } rfmm_dec_t;

  typedef struct packed {
    logic valid;
    logic pair;
    logic prod;
    logic [4:0] idx;
  } rfmm_reg_sel_t;

endpackage

// ### rfmm_fetch_model.sv
`timescale 1ns/1ps
module rfmm_fetch_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic fetch_ready_i,
  output logic fetch_valid_o,
  output logic [15:0] fetch_word_o,
  output logic dec_ready_o
);
  initial begin
    fetch_valid_o = 1'b0;
    fetch_word_o = 16'h0000;
    dec_ready_o = 1'b0;
  end

  // slow consumer takes a decode only every other cycle
  always @(posedge clk_i) begin
    dec_ready_o <= slow_i ? ~dec_ready_o : 1'b1;
  end

  // word held until taken; an immediate follows its first word at once
  task automatic send(input logic [15:0] w);
    fetch_valid_o <= 1'b1;
    fetch_word_o <= w;
    do @(posedge clk_i); while (!fetch_ready_i);
  endtask

  // released bus shows the inverse of the last word, not a stale copy
  task automatic idle();
    fetch_valid_o <= 1'b0;
    fetch_word_o <= ~fetch_word_o;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_n_i, slow;
  logic fetch_valid_i, fetch_ready_o, byte_op_i, dec_valid_o, dec_ready_i;
  logic [15:0] fetch_word_i, legacy_word_i, macro_addr_o, legacy_opcode_o, stack_addr_o;
  rfmm_pkg::rfmm_dec_t dec_o;
  logic [31:0] src_operand_o, wr_data_i, prod_data_i, cm_addr_o;
  logic legacy_valid_i, macro_valid_o, macro_invalid_o, wr_en_i, wr_byte_i, prod_wr_i;
  logic stack_valid_o, cm_req_i, cm_write_i, cm_valid_o, cm_write_o, capture_i;
  logic [4:0] wr_dest_i;
  rfmm_pkg::rfmm_stack_op_t stack_op_i;
  logic [19:0] program_counter_i, saved_counter_o;
  int err_total, checked;
  logic [31:0] rs, prod, r;
  logic [15:0] gp [20];
  logic [15:0] sp, w;
  logic [95:0] e;
  logic [95:0] dq[$], mq[$], sq[$], cq[$];

  rfmm_decoder rfmm_decoder_i (.clk_i, .rst_n_i, .fetch_valid_i, .fetch_word_i,
    .fetch_ready_o, .byte_op_i, .dec_valid_o, .dec_ready_i, .dec_o, .src_operand_o,
    .legacy_valid_i, .legacy_word_i, .macro_valid_o, .macro_addr_o, .macro_invalid_o,
    .legacy_opcode_o, .wr_en_i, .wr_dest_i, .wr_byte_i, .wr_data_i, .prod_wr_i,
    .prod_data_i, .stack_op_i, .stack_addr_o, .stack_valid_o, .cm_req_i, .cm_write_i,
    .cm_addr_o, .cm_valid_o, .cm_write_o, .capture_i, .program_counter_i,
    .saved_counter_o);

  rfmm_fetch_model rfmm_fetch_model_i (.clk_i(clk_i), .slow_i(slow),
    .fetch_ready_i(fetch_ready_o), .fetch_valid_o(fetch_valid_i),
    .fetch_word_o(fetch_word_i), .dec_ready_o(dec_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic int sgl(input logic [4:0] c);
    if (!c[4]) return int'(c);
    case (c)
      5'h11: return 16;
      5'h13: return 17;
      5'h19: return 18;
      5'h1b: return 19;
      default: return -1;
    endcase
  endfunction

  // even register of a pair carries the upper half
  function automatic int pr(input logic [4:0] c);
    if (c == 5'h15) return 16;
    if (c == 5'h1d) return 18;
    return int'(c[3:0]);
  endfunction

  function automatic logic [31:0] opnd(input logic [4:0] c);
    if (sgl(c) >= 0) return {{16{gp[sgl(c)][15]}}, gp[sgl(c)]};
    if (c == 5'h17) return 32'h0000_0000;
    return {gp[pr(c)], gp[pr(c) + 1]};
  endfunction

  function automatic logic [32:0] mac(input logic [15:0] x);
    logic [7:0] o;
    o = x[15:8];
    if (o < 8'h40) return {16'h0020 + {6'h00, o[5:2], 6'h00}, 1'b0, x};
    if (o < 8'h44) return {16'h0030 + {6'h00, x[7:4], 6'h00}, 1'b0, x};
    if (o >= 8'h50) return {4'h0, o, 4'h0, 1'b0, x};
    if (o == 8'h48) return {16'h0480, 1'b0, x};
    if (o == 8'h49) return {16'h0490, 1'b0, x};
    if (o == 8'h4f) return {16'h02d0, 1'b0, x};
    if (o == 8'h4a && x[3:0] != 4'h0 && x[3:0] < 4'hc)
      return {16'h0050 + {6'h00, x[3:0] - 4'h1, 6'h00}, 1'b0, x};
    return {16'h0010, 1'b1, x};
  endfunction

  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // caller lowers the strobe after the last write
  task automatic wr(input logic [4:0] c, input logic [31:0] d, input logic b);
    wr_en_i <= 1'b1;
    wr_dest_i <= c;
    wr_data_i <= d;
    wr_byte_i <= b;
    @(posedge clk_i);
    if (b) gp[sgl(c)][7:0] = d[7:0];
    else if (sgl(c) >= 0) gp[sgl(c)] = d[15:0];
    else if (c == 5'h1f) prod = d;
    else if (c != 5'h17) begin
      gp[pr(c)] = d[31:16];
      gp[pr(c) + 1] = d[15:0];
    end
  endtask

  task automatic dec(input logic [15:0] x, input logic [15:0] im, input logic bo);
    logic lg;
    logic [31:0] op;
    lg = !x[15] && x[4:0] == 5'h1f;
    if (x[15]) op = {{27{x[4]}}, x[4:0]};
    else if (lg) op = {{16{im[15]}}, im};
    else op = opnd(x[4:0]);
    if (bo) op = {24'h00_0000, op[7:0]};
    dq.push_back({x[15], x[14:10], x[9:5], x[4:0], lg, lg ? im : 16'h0000, op});
    byte_op_i <= bo;
    rfmm_fetch_model_i.send(x);
    if (lg) rfmm_fetch_model_i.send(im);
  endtask

  always @(posedge clk_i) begin
    if (dec_valid_o && dec_ready_i) begin
      e = dq.pop_front();
      chk("dec", 64'(e[64:32]), 64'(dec_o));
      chk("operand", 64'(e[31:0]), 64'(src_operand_o));
    end
    if (macro_valid_o) begin
      e = mq.pop_front();
      chk("macro", 64'(e[32:0]), 64'({macro_addr_o, macro_invalid_o, legacy_opcode_o}));
    end
    if (stack_valid_o) chk("stack", 64'(sq.pop_front()), 64'(stack_addr_o));
    if (cm_valid_o) chk("cm", 64'(cq.pop_front()), 64'({cm_write_o, cm_addr_o}));
  end

  initial begin
    #(25 * 20000);
    err_total++;
    tally_and_finish();
  end

  initial begin
    {rst_n_i, slow, byte_op_i, legacy_valid_i, wr_en_i, wr_byte_i, prod_wr_i} = '0;
    {cm_req_i, cm_write_i, capture_i, wr_dest_i, wr_data_i, prod_data_i} = '0;
    {legacy_word_i, program_counter_i} = '0;
    stack_op_i = rfmm_pkg::RFMM_STK_NONE;
    err_total = 0;
    checked = 0;
    rs = 32'd94;
    sp = 16'h0000;
    prod = 32'h0000_0000;
    foreach (gp[i]) gp[i] = 16'h0000;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int c = 0; c < 32; c++) if (c != 23) wr(5'(c), rnd(), 1'b0);
    wr(5'h03, rnd(), 1'b1);
    wr_en_i <= 1'b0;
    @(posedge clk_i);
    // every source code, register then literal mode, with stalls in the second half of each mode
    for (int c = 0; c < 64; c++) begin
      w = 16'(rnd());
      w[15] = c[5];
      w[4:0] = 5'(c);
      slow <= c[4];
      dec(w, 16'(rnd()), c[1:0] == 2'b11);
    end
    rfmm_fetch_model_i.idle();
    while (dq.size() > 0) @(posedge clk_i);
    // back-to-back translation of every opcode, indexed nibble and immediate form
    for (int i = 0; i < 336; i++) begin
      w = 16'(rnd());
      if (i < 256) w[15:8] = 8'(i);
      else if (i < 320) w[15:4] = {6'h10, 6'(i)};
      else w = {8'h4a, w[7:4], 4'(i)};
      legacy_valid_i <= 1'b1;
      legacy_word_i <= w;
      mq.push_back(mac(w));
      @(posedge clk_i);
    end
    legacy_valid_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (i == 0 || i == 1 || i == 3) begin
        sp = sp - 16'h0001;
        sq.push_back(sp);
        stack_op_i <= rfmm_pkg::RFMM_STK_PUSH;
      end else begin
        sq.push_back(sp);
        sp = sp + 16'h0001;
        stack_op_i <= rfmm_pkg::RFMM_STK_POP;
      end
      @(posedge clk_i);
    end
    stack_op_i <= rfmm_pkg::RFMM_STK_NONE;
    // product result wins over a same-cycle register write
    r = rnd();
    prod_wr_i <= 1'b1;
    prod_data_i <= r;
    wr(5'h1f, rnd(), 1'b0);
    prod = r;
    prod_wr_i <= 1'b0;
    wr_en_i <= 1'b0;
    cm_req_i <= 1'b1;
    cm_write_i <= 1'b1;
    cq.push_back({1'b1, prod});
    @(posedge clk_i);
    cm_req_i <= 1'b0;
    wr(5'h1f, rnd(), 1'b0);
    wr_en_i <= 1'b0;
    cm_req_i <= 1'b1;
    cm_write_i <= 1'b0;
    cq.push_back({1'b0, prod});
    @(posedge clk_i);
    cm_req_i <= 1'b0;
    r = rnd();
    capture_i <= 1'b1;
    program_counter_i <= r[19:0];
    @(posedge clk_i);
    capture_i <= 1'b0;
    program_counter_i <= ~r[19:0];
    repeat (2) @(posedge clk_i);
    chk("saved", 64'(r[19:0]), 64'(saved_counter_o));
    repeat (4) @(posedge clk_i);
    // a missing pulse leaves its note behind
    chk("pending", 64'h0, 64'(dq.size() + mq.size() + sq.size() + cq.size()));
    tally_and_finish();
  end
endmodule
